// ==== core/cic_top.sv ====
/*
 * Core interrupt control register with its APB slave, the event flag
 * logic for timer-zero overflow, external pin and upper port change,
 * the request to the core, and a sticky status / mask pair that drives
 * one level interrupt line.
 * Assumes timer_zero_overflow is a one-cycle pulse from logic on pclk,
 * and that external_irq_pin and upper_port_pins come from pins. An external
 * pin already high when reset ends is not an edge; a high port pin is a change.
 */
`timescale 1ns/100ps

// Behaviour
// - Flags set regardless of any enable
// - All control bits readable and writable
// - Bit 7 globally allows or blocks the request to the core; the level irq ignores it
// - Bit 6 allows or blocks peripheral interrupts
// - Bit 5 enables timer-zero overflow interrupt
// - Bit 4 enables external pin interrupt
// - Bit 3 enables upper port change interrupt
// - Bit 2 set on timer overflow
// - Bit 1 set on external pin event
// - Bit 0 set on upper pin change
// - Mismatch persists until port read or pins return to the reference value
// - Peripheral interrupts need group enable too
module cic_top
    import cic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CIC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_zero_overflow,
    input wire logic external_irq_pin,
    input wire logic [CIC_PORT_W-1:0] upper_port_pins,
    input wire logic peripheral_irq,
    output logic core_irq_req,
    output logic irq
);

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [CIC_EV_W-1:0] stat_q;
    logic [CIC_EV_W-1:0] stat_d;
    logic [CIC_EV_W-1:0] mask_q;
    logic [31:0] rdata_q;
    logic slverr_q;
    logic ext_sync;
    logic ext_prev_q;
    logic ext_event;
    logic [CIC_PORT_W-1:0] port_sync;
    logic [CIC_PORT_W-1:0] port_seen;
    logic port_mismatch;
    logic port_read;
    logic setup;
    logic access;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic [2:0] flag_set;
    logic [CIC_EV_W-1:0] ev_set;
    logic timer_term;
    logic ext_term;
    logic port_term;
    logic periph_term;
    logic req_q;

    // Register select and bus qualifiers
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic sel_port;
    logic wr_lane0;
    logic req_d;
    logic [2:0] ext_warm_q;
    logic unused_strb;

    // Unmapped offsets are refused with an error
    function automatic logic is_mapped(input logic [CIC_AW-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a == CIC_CTRL_ADDR) begin
            hit = 1'b1;
        end else if (a == CIC_STAT_ADDR) begin
            hit = 1'b1;
        end else if (a == CIC_MASK_ADDR) begin
            hit = 1'b1;
        end else if (a == CIC_PORT_ADDR) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // One-hot select, in the order port, mask, status, control; shared
    // by the write strobes and the read path
    function automatic logic [3:0] decode_sel(input logic [CIC_AW-1:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        if (a == CIC_CTRL_ADDR) begin
            sel = 4'h1;
        end else if (a == CIC_STAT_ADDR) begin
            sel = 4'h2;
        end else if (a == CIC_MASK_ADDR) begin
            sel = 4'h4;
        end else if (a == CIC_PORT_ADDR) begin
            sel = 4'h8;
        end
        return sel;
    endfunction

    // Only the selected register reaches the bus; the rest reads as zero
    function automatic logic [31:0] read_word(
        input logic [3:0] sel,
        input logic [7:0] ctrl,
        input logic [CIC_EV_W-1:0] stat,
        input logic [CIC_EV_W-1:0] mask,
        input logic [CIC_PORT_W-1:0] port
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        if (sel == 4'h1) begin
            word[7:0] = ctrl;
        end else if (sel == 4'h2) begin
            word[CIC_EV_W-1:0] = stat;
        end else if (sel == 4'h4) begin
            word[CIC_EV_W-1:0] = mask;
        end else if (sel == 4'h8) begin
            word[CIC_PORT_W-1:0] = port;
        end
        return word;
    endfunction

    // Hardware set is applied after the software update so it wins
    function automatic logic [7:0] merge_set(
        input logic [7:0] cur,
        input logic we,
        input logic [7:0] wval,
        input logic [7:0] set
    );
        logic [7:0] nxt;
        nxt = we ? wval : cur;
        return nxt | set;
    endfunction

    // Write-one-to-clear with the same set-wins ordering
    function automatic logic [CIC_EV_W-1:0] w1c_set(
        input logic [CIC_EV_W-1:0] cur,
        input logic we,
        input logic [CIC_EV_W-1:0] clr,
        input logic [CIC_EV_W-1:0] set
    );
        logic [CIC_EV_W-1:0] nxt;
        nxt = we ? (cur & ~clr) : cur;
        return nxt | set;
    endfunction

    // Pin inputs cross into pclk

    cic_sync #(
        .WIDTH(1)
    ) u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(external_irq_pin),
        .sync_out(ext_sync)
    );

    cic_sync #(
        .WIDTH(CIC_PORT_W)
    ) u_port_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(upper_port_pins),
        .sync_out(port_sync)
    );

    cic_port_watch u_port_watch (
        .pclk(pclk),
        .presetn(presetn),
        .pins_sync(port_sync),
        .port_read(port_read),
        .seen_q(port_seen),
        .mismatch(port_mismatch)
    );

    // External pin event: rising edge of the synchronised pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_sync;
        end
    end

    // A pin already high at reset release is a level, not an edge, so
    // edges count only once the synchroniser and the history hold real
    // pin samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_warm_q <= 3'h0;
        end else begin
            ext_warm_q <= {ext_warm_q[1:0], 1'b1};
        end
    end

    assign ext_event = ext_warm_q[2] && ext_sync && !ext_prev_q;

    // APB decode

    assign setup = psel && !penable;
    assign access = psel && penable;
    // Zero wait state: read data and error are prepared in setup
    assign pready = access;

    assign {sel_port, sel_mask, sel_stat, sel_ctrl} = decode_sel(paddr);
    // Byte 0 carries every bit; a write without it is dropped quietly
    assign wr_lane0 = access && pwrite && pstrb[0];
    assign wr_ctrl = wr_lane0 && sel_ctrl;
    assign wr_stat = wr_lane0 && sel_stat;
    assign wr_mask = wr_lane0 && sel_mask;
    assign port_read = access && !pwrite && sel_port;

    // Hardware sets of the control flags, independent of enables
    always_comb begin
        flag_set = 3'h0;
        flag_set[CIC_TIMER_FLAG_BIT] = timer_zero_overflow;
        flag_set[CIC_EXIF_BIT] = ext_event;
        // A live mismatch keeps setting the flag, so a clear only holds
        // once the port has been read or the pins are back at the reference value
        flag_set[CIC_PCIF_BIT] = port_mismatch;
    end

    always_comb begin
        ctrl_d = merge_set(ctrl_q, wr_ctrl, pwdata[7:0],
            {5'h00, flag_set});
    end

    // Enables and flags share one register and one write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CIC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Request to the core

    assign timer_term = ctrl_q[CIC_TIMER_EN_BIT] &&
        ctrl_q[CIC_TIMER_FLAG_BIT];
    assign ext_term = ctrl_q[CIC_EXIE_BIT] &&
        ctrl_q[CIC_EXIF_BIT];
    assign port_term = ctrl_q[CIC_PCIE_BIT] &&
        ctrl_q[CIC_PCIF_BIT];
    assign periph_term = ctrl_q[CIC_GROUP_EN_BIT] &&
        peripheral_irq;

    // Group term carries its own enable; all terms share the global one
    always_comb begin
        req_d = timer_term || ext_term || port_term || periph_term;
        req_d = req_d && ctrl_q[CIC_GLOBAL_EN_BIT];
    end

    // Registered so the request is glitch free toward the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end

    assign core_irq_req = req_q;

    // Sticky event status, write one to clear

    always_comb begin
        ev_set = CIC_EV_RESET;
        // Marks a new mismatch once, not every cycle that it lasts
        ev_set[CIC_EV_PORT] = port_mismatch && !ctrl_q[CIC_PCIF_BIT];
        ev_set[CIC_EV_EXT] = ext_event;
        ev_set[CIC_EV_TIMER] = timer_zero_overflow;
        stat_d = w1c_set(stat_q, wr_stat, pwdata[CIC_EV_W-1:0], ev_set);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= CIC_EV_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Mask has the status layout and gates only the level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= CIC_EV_RESET;
        end else if (wr_mask) begin
            mask_q <= pwdata[CIC_EV_W-1:0];
        end
    end

    // Level output: stays high until the bit is cleared or masked
    assign irq = |(stat_q & mask_q);

    // Read data and error, captured in the setup cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            // Flag set in the setup cycle itself is included
            rdata_q <= read_word({sel_port, sel_mask, sel_stat, sel_ctrl},
                ctrl_d, stat_d, mask_q, port_sync);
        end
    end

    // Error follows the setup address and is shown only in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_q <= 1'b0;
        end else if (setup) begin
            slverr_q <= !is_mapped(paddr);
        end
    end

    assign prdata = rdata_q;
    assign pslverr = access && slverr_q;

    // Reference value is only observed through the mismatch
    logic unused_seen;
    assign unused_seen = |port_seen;

    // Upper byte lanes carry no register bits
    assign unused_strb = |pstrb[3:1];

endmodule

// ==== core/cic_pkg.sv ====
/*
 * Constants for the core interrupt control block: register indices and
 * byte addresses, bit positions of the control register, reset values
 * and the layout of the event status and mask registers.
 * Assumes a 12-bit APB byte address with 32-bit aligned registers.
 */
package cic_pkg;

    localparam int CIC_AW = 12;

    // Offsets are word indices; the byte address is four times the index
    localparam logic [9:0] CIC_CTRL_IDX = 10'h00B;
    localparam logic [9:0] CIC_STAT_IDX = 10'h00C;
    localparam logic [9:0] CIC_MASK_IDX = 10'h00D;
    localparam logic [9:0] CIC_PORT_IDX = 10'h00E;

    localparam logic [CIC_AW-1:0] CIC_CTRL_ADDR = {CIC_CTRL_IDX, 2'b00};
    localparam logic [CIC_AW-1:0] CIC_STAT_ADDR = {CIC_STAT_IDX, 2'b00};
    localparam logic [CIC_AW-1:0] CIC_MASK_ADDR = {CIC_MASK_IDX, 2'b00};
    localparam logic [CIC_AW-1:0] CIC_PORT_ADDR = {CIC_PORT_IDX, 2'b00};

    // Control register bit positions
    localparam int CIC_GLOBAL_EN_BIT = 7;
    localparam int CIC_GROUP_EN_BIT = 6;
    localparam int CIC_TIMER_EN_BIT = 5;
    localparam int CIC_EXIE_BIT = 4;
    localparam int CIC_PCIE_BIT = 3;
    localparam int CIC_TIMER_FLAG_BIT = 2;
    localparam int CIC_EXIF_BIT = 1;
    localparam int CIC_PCIF_BIT = 0;

    localparam logic [7:0] CIC_CTRL_RESET = 8'h00;

    // Event status and mask layout
    localparam int CIC_EV_W = 3;
    localparam int CIC_EV_PORT = 0;
    localparam int CIC_EV_EXT = 1;
    localparam int CIC_EV_TIMER = 2;
    localparam logic [CIC_EV_W-1:0] CIC_EV_RESET = 3'h0;

    localparam int CIC_PORT_W = 4;
    localparam logic [CIC_PORT_W-1:0] CIC_PORT_RESET = 4'h0;

endpackage

// ==== core/cic_sync.sv ====
/*
 * Two-stage synchroniser for a group of level inputs from pins.
 * Assumes the inputs are asynchronous to pclk; only the second stage
 * may be read by other logic.
 */
`timescale 1ns/100ps

module cic_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== core/cic_port_watch.sv ====
/*
 * Change watcher for the upper port pins: keeps the value last read by
 * software and reports a mismatch against the live, synchronised pins.
 * Assumes port_read is a one-cycle pulse at the completing APB read.
 */
`timescale 1ns/100ps

module cic_port_watch
    import cic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CIC_PORT_W-1:0] pins_sync,
    input wire logic port_read,
    output logic [CIC_PORT_W-1:0] seen_q,
    output logic mismatch
);

    logic armed_q;

    // A mismatch ends when the port is read or when the pins return to the reference value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= CIC_PORT_RESET;
        end else if (port_read || !armed_q) begin
            seen_q <= pins_sync;
        end
    end

    // Take the first sample, the synchroniser's reset zero, as reference; a pin high at reset is a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    assign mismatch = armed_q && (pins_sync != seen_q);

endmodule

// ==== verif/cic_top_asserts.sv ====
/*
 * Checker for cic_top: APB answers, read-back and request gating.
 * Assumes it is bound to cic_top and sees only its ports.
 */
`timescale 1ns/100ps

module cic_top_chk
    import cic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CIC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_zero_overflow,
    input wire logic external_irq_pin,
    input wire logic [CIC_PORT_W-1:0] upper_port_pins,
    input wire logic peripheral_irq,
    input wire logic core_irq_req,
    input wire logic irq
);
    logic [7:0] en_q;
    logic [7:0] en_old_q;
    logic [2:0] mk_q;
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {CIC_CTRL_ADDR, CIC_STAT_ADDR, CIC_MASK_ADDR,
        CIC_PORT_ADDR};
    // Shadow of software writes; the request lags the register by one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h00;
            en_old_q <= 8'h00;
            mk_q <= 3'h0;
        end else begin
            en_old_q <= en_q;
            if (acc && pwrite && pstrb[0] && paddr == CIC_CTRL_ADDR) begin
                en_q <= pwdata[7:0];
            end
            if (acc && pwrite && pstrb[0] && paddr == CIC_MASK_ADDR) begin
                mk_q <= pwdata[2:0];
            end
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_unmap; acc && !hit |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_mapped; acc && hit |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_rdback;
        acc && !pwrite && paddr == CIC_CTRL_ADDR |-> prdata[7:3] == en_q[7:3];
    endproperty
    a_rdback: assert property (p_rdback) else $error("enable bits lost");
    property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_gie_off;
        !en_q[7] && !en_old_q[7] |-> !core_irq_req;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("req no global");
    property p_grp_off;
        en_q[6:3] == 4'h0 && en_old_q[6:3] == 4'h0 |-> !core_irq_req;
    endproperty
    a_grp_off: assert property (p_grp_off) else $error("req no enable");
    property p_periph;
        peripheral_irq && en_q[7] && en_q[6] |-> ##[1:2] core_irq_req;
    endproperty
    a_periph: assert property (p_periph) else $error("periph lost");
    property p_irq_mask; irq |-> mk_q != 3'h0; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    cover property (core_irq_req);
    cover property (irq);
    cover property (acc && pslverr);
endmodule

bind cic_top cic_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timer_zero_overflow,
    .external_irq_pin, .upper_port_pins, .peripheral_irq, .core_irq_req, .irq);

// ==== verif/cic_src.sv ====
/*
 * Event sources beside the block: timer overflow, pin and port levels.
 * Assumes tasks are called from the bench between clock edges.
 */
`timescale 1ns/100ps

module cic_src (
    input wire logic pclk,
    output logic ovf,
    output logic ext_pin,
    output logic [3:0] port_pins,
    output logic periph
);
    initial begin
        ovf = 1'b0;
        ext_pin = 1'b0;
        port_pins = 4'h0;
        periph = 1'b0;
    end
    task automatic pulse_timer();
        @(posedge pclk);
        ovf <= 1'b1;
        @(posedge pclk);
        ovf <= 1'b0;
    endtask
    task automatic drive(input logic e, input logic [3:0] p, input logic q);
        @(posedge pclk);
        ext_pin <= e;
        port_pins <= p;
        periph <= q;
    endtask
endmodule

// ==== verif/test_cic_top.sv ====
/*
 * Self-checking bench for cic_top driven over APB.
 * Assumes cic_src supplies the events and the checker is bound.
 */
`timescale 1ns/100ps

module test_cic_top
    import cic_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic [31:0] r;
    logic pready, pslverr, core_irq_req, irq, err, ovf, ext_pin, periph;
    logic [3:0] port_pins;
    int error_cnt = 0;
    int n_tests = 0;
    // Entries are {peripheral level, expected request, control value}
    logic [9:0] tbl [10] = '{10'h084, 10'h1A4, 10'h082, 10'h192, 10'h081,
        10'h189, 10'h009, 10'h280, 10'h3C0, 10'h240};

    always #5 pclk = ~pclk;

    cic_src src (.pclk, .ovf, .ext_pin, .port_pins, .periph);
    cic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .timer_zero_overflow(ovf),
        .external_irq_pin(ext_pin), .upper_port_pins(port_pins),
        .peripheral_irq(periph), .core_irq_req, .irq);

    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(CIC_CTRL_ADDR, 32'h00);
        rd(CIC_MASK_ADDR, 32'h00);
        apb(1'b1, CIC_CTRL_ADDR, 32'hFF);
        rd(CIC_CTRL_ADDR, 32'hFF);
        apb(1'b1, CIC_CTRL_ADDR, 32'h00);
        src.pulse_timer();
        rd(CIC_CTRL_ADDR, 32'h04);
        rd(CIC_STAT_ADDR, 32'h04);
        apb(1'b1, CIC_MASK_ADDR, 32'h04);
        idle(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, CIC_STAT_ADDR, 32'h04);
        idle(1);
        chk({31'h0, irq}, 32'h0);
        src.drive(1'b1, 4'h0, 1'b0);
        idle(6);
        rd(CIC_CTRL_ADDR, 32'h06);
        apb(1'b1, CIC_CTRL_ADDR, 32'h00);
        rd(CIC_CTRL_ADDR, 32'h00);
        src.drive(1'b1, 4'hA, 1'b0);
        idle(4);
        rd(CIC_CTRL_ADDR, 32'h01);
        apb(1'b1, CIC_CTRL_ADDR, 32'h00);
        rd(CIC_CTRL_ADDR, 32'h01);
        rd(CIC_PORT_ADDR, 32'h0A);
        apb(1'b1, CIC_CTRL_ADDR, 32'h00);
        rd(CIC_CTRL_ADDR, 32'h00);
        rd(CIC_STAT_ADDR, 32'h03);
        pstrb <= 4'hE;
        apb(1'b1, CIC_CTRL_ADDR, 32'hFF);
        pstrb <= 4'hF;
        rd(CIC_CTRL_ADDR, 32'h00);
        foreach (tbl[i]) begin
            src.drive(1'b1, 4'hA, tbl[i][9]);
            apb(1'b1, CIC_CTRL_ADDR, {24'h0, tbl[i][7:0]});
            idle(2);
            chk({31'h0, core_irq_req}, {31'h0, tbl[i][8]});
        end
        apb(1'b1, 12'h03C, 32'hFF);
        rd(12'h03C, 32'h00);
        chk({31'h0, err}, 32'h1);
        report_and_stop();
    end
endmodule
